// file: include/pwr_pkg.sv
package pwr_pkg;

    // ========================================================
    // register map (byte addresses on the ahb-lite bus)
    // ========================================================
    localparam logic [7:0] PCTL_OFF   = 8'h00; // power_control_reg
    localparam logic [7:0] PORT_OFF   = 8'h04; // port latch image
    localparam logic [7:0] STAT_OFF   = 8'h08; // sticky event status
    localparam logic [7:0] CLR_OFF    = 8'h0C; // write-one-to-clear
    localparam logic [7:0] IEN_OFF    = 8'h10; // interrupt enable
    localparam logic [7:0] MODE_OFF   = 8'h14; // state / wake config

    // ========================================================
    // power_control_reg fields
    // ========================================================
    localparam int IDLE_BIT = 0;  // idle_request_bit
    localparam int PWRDN_BIT = 1; // power_down_bit
    localparam int COLD_BIT = 4;  // cold_start_flag

    // wake configuration fields in MODE register
    localparam int WEN0_BIT = 0;  // ext_irq_zero wake enable
    localparam int WEN1_BIT = 1;  // ext_irq_one wake enable
    localparam int LVL0_BIT = 2;  // ext_irq_zero level sensitive
    localparam int LVL1_BIT = 3;  // ext_irq_one level sensitive

    // status event bits
    localparam int EV_DOWN = 0;   // entered power-down
    localparam int EV_WAKE = 1;   // woke by interrupt
    localparam int EV_IDLE = 2;   // entered idle

    // ========================================================
    // reset values and timing
    // ========================================================
    localparam logic [7:0] PCTL_RST  = 8'h00;
    localparam logic [7:0] PORT_RST  = 8'hFF;
    localparam logic [3:0] MODE_RST  = 4'h0;
    localparam int CLK_HZ        = 25_000_000;
    localparam int SETTLE_US     = 10_000;   // 10 msec oscillator settle
    localparam int SETTLE_CYC    = SETTLE_US * (CLK_HZ / 1_000_000);

    typedef enum {ST_RUN, ST_IDLE, ST_DOWN, ST_SETTLE, ST_ISR} pstate_t;

    // ahb-lite request carried as a struct
    typedef struct packed {
        logic        sel;
        logic [1:0]  trans;
        logic        write;
        logic [2:0]  size;
        logic [31:0] addr;
    } ahb_req_t;

    // wake pins after synchronisation
    typedef struct packed {
        logic irq0_n;
        logic irq1_n;
    } wake_pins_t;

endpackage

// file: verilog/pwr_wake_sync.sv
// two flip-flop synchroniser for the wake pins; the async low level
// is separately used to restart the oscillator, bypassing both stages
module pwr_wake_sync (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // raw pins and synchronised copy
    input  wire logic                irq0_n_pin,
    input  wire logic                irq1_n_pin,
    output      pwr_pkg::wake_pins_t pins_s
);
    import pwr_pkg::*;

    logic [1:0] meta_r;
    logic [1:0] sync_r;

    // ========================================================
    // synchroniser; first stage feeds only the second
    // ========================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= 2'h3;
            sync_r <= 2'h3;
        end else begin
            meta_r <= {irq1_n_pin, irq0_n_pin};
            sync_r <= meta_r;
        end
    end

    assign pins_s = '{irq0_n: sync_r[0], irq1_n: sync_r[1]};

endmodule

// file: verilog/pwr_ctrl.sv
// ========================================================
// ========================================================
module pwr_ctrl #(
    parameter int SETTLE = pwr_pkg::SETTLE_CYC
) (
    // clock, resets
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        por_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output      logic [31:0] hrdata,
    output      logic        hreadyout,
    output      logic        hresp,
    // wake pins
    input  wire logic        irq0_n,
    input  wire logic        irq1_n,
    // core side
    input  wire logic        return_from_interrupt,
    output      logic        osc_en,
    output      logic        core_run,
    output      logic        isr_req,
    output      logic        ale,
    output      logic        prog_fetch_n,
    output      logic [7:0]  port_out,
    output      logic        irq
);
    import pwr_pkg::*;

    // ========================================================
    // state
    // ========================================================
    pstate_t     st_r, st_nxt;
    logic [7:0]  pctl_r;
    logic [7:0]  port_r;
    logic [3:0]  mode_r;
    logic [2:0]  stat_r, ien_r;
    logic [31:0] cnt_r;
    logic        cold_r;
    logic        wr_ph_r;
    logic [7:0]  wa_r;
    logic [31:0] hrdata_r;
    logic        irq_r, osc_r, run_r, isr_r;
    logic        ale_r, fetch_r;
    logic [7:0]  pout_r;
    wake_pins_t  pins_s;

    pwr_wake_sync u_sync (
        .clk        (clk),
        .nrst       (nrst),
        .irq0_n_pin (irq0_n),
        .irq1_n_pin (irq1_n),
        .pins_s     (pins_s)
    );

    // ========================================================
    // bus decode
    // ========================================================
    wire        req     = hsel && hready && htrans[1];
    wire        wr_now  = wr_ph_r;
    wire        w_pctl  = wr_now && wa_r == PCTL_OFF;
    wire        w_port  = wr_now && wa_r == PORT_OFF;
    wire        w_clr   = wr_now && wa_r == CLR_OFF;
    wire        w_ien   = wr_now && wa_r == IEN_OFF;
    wire        w_mode  = wr_now && wa_r == MODE_OFF;
    wire        down_req = w_pctl && hwdata[PWRDN_BIT];
    wire        id_req  = w_pctl && hwdata[IDLE_BIT] && !hwdata[PWRDN_BIT];

    // wake when an enabled, level-configured line is low
    wire        lvl0    = mode_r[WEN0_BIT] && mode_r[LVL0_BIT];
    wire        lvl1    = mode_r[WEN1_BIT] && mode_r[LVL1_BIT];
    wire        pin_low = (lvl0 && !pins_s.irq0_n) ||
                          (lvl1 && !pins_s.irq1_n);
    // raw async path restarts the oscillator, registered on one clock edge
    wire        osc_wake = (lvl0 && !irq0_n) || (lvl1 && !irq1_n);
    wire        settled = cnt_r >= SETTLE - 1;
    wire [2:0]  ev;
    assign ev[EV_DOWN] = st_r == ST_RUN && down_req;
    assign ev[EV_WAKE] = st_r == ST_SETTLE && settled && !pin_low;
    assign ev[EV_IDLE] = st_r == ST_RUN && id_req;
    // a new event wins over a clear in the same cycle
    wire [2:0]  stat_nxt = (stat_r & ~(w_clr ? hwdata[2:0] : 3'h0)) | ev;

    // ========================================================
    // next state
    // ========================================================
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN: begin
                if (down_req)
                    st_nxt = ST_DOWN;
                else if (id_req)
                    st_nxt = ST_IDLE;
            end
            ST_IDLE:   if (pin_low) st_nxt = ST_RUN;
            ST_DOWN:   if (pin_low) st_nxt = ST_SETTLE;
            // wait for the settle count and the pin back high
            ST_SETTLE: if (settled && !pin_low) st_nxt = ST_ISR;
            ST_ISR:    if (return_from_interrupt) st_nxt = ST_RUN;
            default:   st_nxt = ST_RUN;
        endcase
    end

    // ========================================================
    // state, counter and bus phase
    // ========================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r    <= ST_RUN;
            cnt_r   <= 32'h0;
            wr_ph_r <= 1'b0;
            wa_r    <= 8'h00;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= (st_r == ST_SETTLE) ? cnt_r + 32'h1 : 32'h0;
            wr_ph_r <= req && hwrite;
            wa_r    <= haddr[7:0];
        end
    end

    // ========================================================
    // registers; bus writes still land while frozen
    // ========================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pctl_r <= PCTL_RST;
            port_r <= PORT_RST;
            mode_r <= MODE_RST;
            ien_r  <= 3'h0;
            stat_r <= 3'h0;
        end else begin
            if (w_pctl)
                pctl_r <= {hwdata[7:5], 1'b0, hwdata[3:0]};
            if (st_r == ST_ISR && return_from_interrupt)
                pctl_r[PWRDN_BIT] <= 1'b0;       // power-down bit cleared
            if (w_port) port_r <= hwdata[7:0];
            if (w_mode) mode_r <= hwdata[3:0];
            if (w_ien)  ien_r  <= hwdata[2:0];
            stat_r <= stat_nxt;
        end
    end

    // cold flag lives on the power-on reset only
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n)
            cold_r <= 1'b1;
        else if (w_pctl)
            cold_r <= hwdata[COLD_BIT];
    end

    // ========================================================
    // registered outputs
    // ========================================================
    wire down   = st_nxt == ST_DOWN;
    wire [31:0] rd_mux =
        (haddr[7:0] == PCTL_OFF) ? {24'h0, pctl_r[7:5], cold_r,
                                    pctl_r[3:0]} :
        (haddr[7:0] == PORT_OFF) ? {24'h0, port_r} :
        (haddr[7:0] == STAT_OFF) ? {29'h0, stat_r} :
        (haddr[7:0] == IEN_OFF)  ? {29'h0, ien_r} :
        (haddr[7:0] == MODE_OFF) ? {25'h0, 3'(st_r), mode_r} : 32'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata_r <= 32'h0;
            irq_r    <= 1'b0;
            osc_r    <= 1'b1;
            run_r    <= 1'b1;
            isr_r    <= 1'b0;
            ale_r    <= 1'b1;
            fetch_r  <= 1'b1;
            pout_r   <= PORT_RST;
        end else begin
            hrdata_r <= (req && !hwrite) ? rd_mux : hrdata_r;
            // follow the next status so a clear drops irq at once
            irq_r    <= |(stat_nxt & (w_ien ? hwdata[2:0] : ien_r));
            osc_r    <= !down || osc_wake;
            run_r    <= st_nxt == ST_RUN || st_nxt == ST_ISR;
            isr_r    <= st_nxt == ST_ISR;
            ale_r    <= !down;
            fetch_r  <= !down;
            pout_r   <= w_port ? hwdata[7:0] : port_r;
        end
    end

    assign hrdata       = hrdata_r;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign irq          = irq_r;
    assign osc_en       = osc_r;
    assign core_run     = run_r;
    assign isr_req      = isr_r;
    assign ale          = ale_r;
    assign prog_fetch_n = fetch_r;
    assign port_out     = pout_r;

    // ========================================================
    // checks
    // ========================================================
    sequence s_down_write;
        st_r == ST_RUN && down_req;
    endsequence

    chk_down_enters: assert property (
        @(posedge clk) disable iff (!nrst)
        s_down_write |=> st_r == ST_DOWN && !run_r)
        else $error("power-down not entered");
    chk_down_wins: assert property (
        @(posedge clk) disable iff (!nrst)
        s_down_write ##0 hwdata[IDLE_BIT] |=> st_r == ST_DOWN)
        else $error("idle taken over power-down");
    chk_strobes_low: assert property (
        @(posedge clk) disable iff (!nrst)
        st_r == ST_DOWN && $past(st_r) == ST_DOWN |-> !ale && !prog_fetch_n)
        else $error("strobes not low in power-down");
    chk_down_stays: assert property (
        @(posedge clk) disable iff (!nrst)
        st_r == ST_DOWN && !pin_low |=> st_r == ST_DOWN)
        else $error("left power-down without wake");
    chk_regs_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        st_r == ST_DOWN && !wr_now |=> $stable(port_r) && $stable(mode_r))
        else $error("registers changed in power-down");
    chk_settle_wait: assert property (
        @(posedge clk) disable iff (!nrst)
        st_r == ST_SETTLE && !settled |=> !core_run)
        else $error("core ran before settle");
    chk_resume_return: assert property (
        @(posedge clk) disable iff (!nrst)
        st_r == ST_ISR && return_from_interrupt |=> st_r == ST_RUN)
        else $error("no resume after return");
    chk_cold_write: assert property (
        @(posedge clk) disable iff (!por_n)
        w_pctl |=> cold_r == $past(hwdata[COLD_BIT]))
        else $error("cold flag write lost");
    chk_osc_wake: assert property (
        @(posedge clk) disable iff (!nrst)
        st_r == ST_DOWN && pin_low |=> osc_en)
        else $error("oscillator not restarted");

endmodule

// file: verif/wake_src.sv
// ========================================================
// external wake source: drives two active-low wake pins, one low per request
// ========================================================
module wake_src #(
    parameter int HOLD = 20
) (
    // clock
    input  wire logic clk,
    // request from the bench: go pulse, line 0 or 1
    input  wire logic go,
    input  wire logic line,
    // wake pins, pulled high when released
    output      logic irq0_n,
    output      logic irq1_n,
    output      logic busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_r = 8'h00;
    logic       line_r = 1'b0;

    // hold the pin low well past the settle time, then let it go high
    always @(posedge clk) begin
        if (go && cnt_r == 8'h00) begin
            cnt_r  <= 8'(HOLD);
            line_r <= line;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    // pin low restarts the clock; returning high finishes the exit
    assign irq0_n = !(cnt_r != 8'h00 && !line_r);
    assign irq1_n = !(cnt_r != 8'h00 && line_r);
    assign busy   = (cnt_r != 8'h00);
endmodule

// file: verif/testbench.sv
// ========================================================
// bench for the power-down controller
// ========================================================
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    num_errors++; $display("unexpected %s exp=%0h got=%0h", nm, ex, got); \
    end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pwr_pkg::*;

    typedef struct packed {
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;

    logic        clk, nrst, por_n, hsel, hwrite, ret_intr, go, line, busy;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, irq0_n, irq1_n, osc_en, core_run;
    logic        isr_req, ale, prog_fetch_n, irq;
    logic [7:0]  port_out;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    row_t        rows[8];

    // short settle count keeps the run brief
    pwr_ctrl #(.SETTLE(8)) dut (.clk(clk), .nrst(nrst), .por_n(por_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq0_n(irq0_n), .irq1_n(irq1_n), .osc_en(osc_en),
        .return_from_interrupt(ret_intr),
        .core_run(core_run), .isr_req(isr_req), .ale(ale),
        .prog_fetch_n(prog_fetch_n), .port_out(port_out), .irq(irq));
    wake_src #(.HOLD(20)) src (.clk(clk), .go(go), .line(line),
        .irq0_n(irq0_n), .irq1_n(irq1_n), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // hang guard: the whole sequence needs well under this
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one ahb-lite single word transfer; waits on hready, never counts
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // pulse a wake request to the partner and let the pin fall
    task automatic wake(input logic ln);
        @(posedge clk);
        go   <= 1'b1;
        line <= ln;
        @(posedge clk);
        go <= 1'b0;
        #1;
    endtask

    task automatic enter_down();
        ahb(1'b1, PCTL_OFF, 32'h00000003, rd); // both bits set
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        {hsel, hwrite, ret_intr, go, line} = 5'h00;
        {htrans, hsize} = 5'h00;
        {haddr, hwdata} = 64'h0;
        nrst  = 1'b0;
        por_n = 1'b0;
        repeat (10) @(posedge clk);
        nrst  <= 1'b1;
        por_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("port_out", 8'hFF, port_out)
        `CHK("osc_en", 1'b1, osc_en)
        ahb(1'b0, PCTL_OFF, 32'h0, rd);
        `CHK("cold_flag", 1'b1, rd[COLD_BIT])
        // ordinary register cases: write then read back
        rows = '{'{PCTL_OFF, 32'h10, 32'h10}, '{PCTL_OFF, 32'h0, 32'h0},
                 '{PORT_OFF, 32'hA5, 32'hA5}, '{MODE_OFF, 32'hF, 32'hF},
                 '{STAT_OFF, 32'hFF, 32'h0}, '{8'h40, 32'hFF, 32'h0},
                 '{IEN_OFF, 32'h7, 32'h7}, '{MODE_OFF, 32'h5, 32'h5}};
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].a[7:0], rows[i].d, rd);
            ahb(1'b0, rows[i].a[7:0], 32'h0, rd);
            `CHK("reg readback", rows[i].e, rd)
        end
        // line zero enabled and level sensitive before power-down
        ahb(1'b1, MODE_OFF, 32'h00000005, rd);
        ahb(1'b1, IEN_OFF, 32'h00000001, rd);
        // power-down wins over idle; strobes low, port held
        enter_down();
        `CHK("core_run down", 1'b0, core_run)
        `CHK("osc_en down", 1'b0, osc_en)
        `CHK("ale down", 1'b0, ale)
        `CHK("fetch down", 1'b0, prog_fetch_n)
        `CHK("port down", 8'hA5, port_out)
        `CHK("irq raised", 1'b1, irq)
        // a line that is not enabled must not wake the core
        wake(1'b1);
        `CHK("osc_en line1", 1'b0, osc_en)
        while (busy === 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
        `CHK("core_run line1", 1'b0, core_run)
        // enabled level line wakes asynchronously, waits for settle
        wake(1'b0);
        // the pin falls after the partner's edge; one edge registers it
        @(posedge clk);
        #1;
        `CHK("osc_en async", 1'b1, osc_en)
        repeat (12) @(posedge clk);
        #1;
        `CHK("core_run settle", 1'b0, core_run)
        for (int k = 0; k < 40 && isr_req !== 1'b1; k++) @(posedge clk);
        #1;
        `CHK("isr_req", 1'b1, isr_req)
        `CHK("core_run isr", 1'b1, core_run)
        `CHK("port kept", 8'hA5, port_out)
        @(posedge clk);
        ret_intr <= 1'b1;
        @(posedge clk);
        ret_intr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("isr_req done", 1'b0, isr_req)
        ahb(1'b0, PCTL_OFF, 32'h0, rd);
        `CHK("down bit after", 1'b0, rd[PWRDN_BIT])
        ahb(1'b0, MODE_OFF, 32'h0, rd);
        `CHK("mode kept", 4'h5, rd[3:0])
        ahb(1'b0, STAT_OFF, 32'h0, rd);
        `CHK("status", 32'h3, rd)
        // clear the enabled event; the remaining one is already masked
        ahb(1'b1, CLR_OFF, 32'h00000001, rd);
        ahb(1'b0, STAT_OFF, 32'h0, rd);
        `CHK("status cleared", 32'h2, rd)
        `CHK("irq cleared", 1'b0, irq)
        // idle alone: core stops, oscillator runs, the wake pin resumes
        ahb(1'b1, PCTL_OFF, 32'h00000001, rd);
        @(posedge clk);
        #1;
        `CHK("core_run idle", 1'b0, core_run)
        `CHK("osc_en idle", 1'b1, osc_en)
        wake(1'b0);
        while (busy === 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
        `CHK("core_run idle exit", 1'b1, core_run)
        ahb(1'b0, STAT_OFF, 32'h0, rd);
        `CHK("status idle", 32'h6, rd)
        // warm reset out of power-down
        enter_down();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("core_run reset", 1'b1, core_run)
        `CHK("port reset", 8'hFF, port_out)
        ahb(1'b0, PCTL_OFF, 32'h0, rd);
        `CHK("warm cold_flag", 32'h0, rd)
        ahb(1'b0, MODE_OFF, 32'h0, rd);
        `CHK("mode reset", 4'h0, rd[3:0])
        tally_and_finish();
    end
endmodule
